/* hw/ebad_area_spec.sv */
// per-area bus specification: width, access states and program waits of one area
`timescale 1ns/10ps
module ebad_area_spec (
	// area setting bits
	input  wire logic       areaWidthBit,
	input  wire logic       areaStateBit,
	input  wire logic       areaWaitHiBit,
	input  wire logic       areaWaitLoBit,
	// resolved specification
	output logic            is8Bit,
	output logic [2:0]      accessStates,
	output logic [2:0]      waitStates
);
	assign is8Bit       = areaWidthBit;
	assign accessStates = areaStateBit ? ebad_pkg::THREE_STATES : ebad_pkg::TWO_STATES;
	// a two-state space ignores the wait bits entirely
	assign waitStates   = areaStateBit ? {1'b0, areaWaitHiBit, areaWaitLoBit} : 3'h0;
endmodule

/* hw/ebad_decoder.sv */
// external bus area decoder: address to area, on-chip/external split, cycle length and chip selects
`timescale 1ns/10ps
module ebad_decoder (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// operating mode straps
	input  wire logic        advancedMode,
	input  wire logic        romEnable,
	input  wire logic        busWidth8Strap,
	// configuration load
	input  wire logic        cfgLoad,
	input  wire logic [7:0]  cfgAreaWidth,
	input  wire logic [7:0]  cfgAreaState,
	input  wire logic [7:0]  cfgWaitHigh,
	input  wire logic [7:0]  cfgWaitLow,
	input  wire logic        cfgPartitionUnit,
	input  wire logic        cfgRamEnable,
	input  wire logic        cfgBurstRom,
	input  wire logic        cfgBurstTwoState,
	input  wire logic [3:0]  cfgCsDirection,
	// access request from internal masters
	input  wire logic        reqValid,
	input  wire logic [23:0] reqAddr,
	// access answer
	output logic             busy,
	output logic             accessDone,
	output logic [2:0]       accessArea,
	output logic             accessExternal,
	output logic             access8Bit,
	output logic             accessBurst,
	output logic [2:0]       accessStates,
	output logic [2:0]       accessWaits,
	// bus mode and configuration state
	output logic             busMode8Bit,
	output logic             partitionUnit,
	output logic             ramEnabled,
	// chip select pins
	output logic [3:0]       chipSelOut_n,
	output logic [3:0]       chipSelOe
);
	////////////////////////////////////////////////////////////////////////////////
	// configuration state
	logic [7:0]  areaWidth_r;
	logic [7:0]  areaState_r;
	logic [7:0]  waitHigh_r;
	logic [7:0]  waitLow_r;
	logic        unit_r;
	logic        ramEn_r;
	logic        burst_r;
	logic        burstTwo_r;
	logic [3:0]  csDir_r;
	logic        strapDone_r;

	// width and chip select direction depend on straps, which may not be sampled under async reset,
	// so they are taken on the first edge after release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			areaWidth_r <= 8'h00;
			areaState_r <= ebad_pkg::STATE_RST;
			waitHigh_r  <= ebad_pkg::WAIT_RST;
			waitLow_r   <= ebad_pkg::WAIT_RST;
			unit_r      <= ebad_pkg::UNIT_RST;
			ramEn_r     <= ebad_pkg::RAM_EN_RST;
			burst_r     <= ebad_pkg::BURST_RST;
			burstTwo_r  <= ebad_pkg::BURST_TWO_RST;
			csDir_r     <= 4'h0;
			strapDone_r <= 1'b0;
		end else if (!strapDone_r) begin
			strapDone_r <= 1'b1;
			areaWidth_r <= {8{busWidth8Strap}};
			csDir_r     <= {3'h0, ~romEnable};
		end else if (cfgLoad) begin
			areaWidth_r <= cfgAreaWidth;
			areaState_r <= cfgAreaState;
			waitHigh_r  <= cfgWaitHigh;
			waitLow_r   <= cfgWaitLow;
			unit_r      <= cfgPartitionUnit;
			ramEn_r     <= cfgRamEnable;
			burst_r     <= cfgBurstRom;
			burstTwo_r  <= cfgBurstTwoState;
			csDir_r     <= cfgCsDirection;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-area specification
	logic [7:0]  specIs8;
	logic [2:0]  specStates [8];
	logic [2:0]  specWaits  [8];

	for (genvar i = 0; i < ebad_pkg::AREA_NUM; i++) begin : gArea
		ebad_area_spec uSpec (
			.areaWidthBit  (areaWidth_r[i]),
			.areaStateBit  (areaState_r[i]),
			.areaWaitHiBit (waitHigh_r[i]),
			.areaWaitLoBit (waitLow_r[i]),
			.is8Bit        (specIs8[i]),
			.accessStates  (specStates[i]),
			.waitStates    (specWaits[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	logic [2:0]  areaNxt;
	logic        onRom;
	logic        onRam;
	logic        onIo;
	logic        extNxt;
	logic        burstNxt;
	logic        is8Nxt;
	logic [2:0]  statesNxt;
	logic [2:0]  waitsNxt;

	always_comb begin
		if (!advancedMode)
			areaNxt = 3'h0;
		else if (unit_r)
			areaNxt = reqAddr[ebad_pkg::IDX_LARGE_LSB +: 3];
		else if (reqAddr[ebad_pkg::ADDR_W-1:ebad_pkg::SMALL_TOP_LSB] != 4'h0)
			areaNxt = ebad_pkg::AREA_TOP;
		else
			areaNxt = reqAddr[ebad_pkg::IDX_SMALL_LSB +: 3];
	end

	// normal mode sees only the low 16 address bits
	always_comb begin
		if (advancedMode) begin
			onRom = romEnable && (reqAddr <= ebad_pkg::ADV_ROM_END);
			onRam = ramEn_r && (reqAddr >= ebad_pkg::ADV_RAM_BASE) && (reqAddr <= ebad_pkg::ADV_RAM_END);
			onIo  = (reqAddr >= ebad_pkg::ADV_IO_BASE);
		end else begin
			onRom = romEnable && (reqAddr[15:0] <= ebad_pkg::NRM_ROM_END);
			onRam = ramEn_r && (reqAddr[15:0] >= ebad_pkg::NRM_RAM_BASE)
				&& (reqAddr[15:0] <= ebad_pkg::NRM_RAM_END);
			onIo  = (reqAddr[15:0] >= ebad_pkg::NRM_IO_BASE);
		end
	end

	always_comb begin
		extNxt   = !(onRom || onRam || onIo);
		// normal mode may take burst ROM for all its space, advanced only area 0
		burstNxt = extNxt && burst_r && (!advancedMode || areaNxt == 3'h0);
		if (onRom || onRam) begin
			is8Nxt    = 1'b0;
			statesNxt = ebad_pkg::MEM_STATES;
			waitsNxt  = 3'h0;
		end else if (onIo) begin
			is8Nxt    = 1'b0;
			statesNxt = ebad_pkg::IO_STATES;
			waitsNxt  = 3'h0;
		end else if (burstNxt) begin
			is8Nxt    = 1'b0;
			statesNxt = burstTwo_r ? ebad_pkg::BURST2_STATES : ebad_pkg::BURST1_STATES;
			waitsNxt  = 3'h0;
		end else begin
			is8Nxt    = specIs8[areaNxt];
			statesNxt = specStates[areaNxt];
			waitsNxt  = specWaits[areaNxt];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// cycle timing: one count per clock, one clock per state
	logic [2:0]  left_r;
	logic        busy_r;
	logic        done_r;
	logic [2:0]  area_r;
	logic        ext_r;
	logic        is8_r;
	logic        burstAcc_r;
	logic [2:0]  states_r;
	logic [2:0]  waits_r;
	logic        take;
	logic [2:0]  totalStates;

	assign take        = reqValid && !busy_r && strapDone_r;
	assign totalStates = statesNxt + waitsNxt;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			left_r <= 3'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= busy_r && (left_r == 3'h0);
			if (take) begin
				busy_r <= 1'b1;
				left_r <= totalStates - 3'h1;
			end else if (busy_r) begin
				if (left_r == 3'h0)
					busy_r <= 1'b0;
				else
					left_r <= left_r - 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			area_r     <= 3'h0;
			ext_r      <= 1'b0;
			is8_r      <= 1'b0;
			burstAcc_r <= 1'b0;
			states_r   <= 3'h0;
			waits_r    <= 3'h0;
		end else if (take) begin
			area_r     <= areaNxt;
			ext_r      <= extNxt;
			is8_r      <= is8Nxt;
			burstAcc_r <= burstNxt;
			states_r   <= statesNxt;
			waits_r    <= waitsNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus mode and chip selects
	logic        busMode8_r;
	logic [3:0]  csOut_r;
	logic [3:0]  csOe_r;
	logic [3:0]  csActNxt;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			busMode8_r <= 1'b0;
		else
			busMode8_r <= (&areaWidth_r) && !burst_r;
	end

	// selects follow the cycle; between back-to-back cycles in the same area the select returns high for one clock
	always_comb begin
		csActNxt = 4'h0;
		if (take && extNxt && areaNxt < 3'h4 && (advancedMode || areaNxt == 3'h0))
			csActNxt[areaNxt[1:0]] = 1'b1;
		else if (busy_r && !(left_r == 3'h0))
			csActNxt = ~csOut_r;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			csOut_r <= 4'hf;
			csOe_r  <= 4'h0;
		end else begin
			csOut_r <= ~csActNxt;
			csOe_r  <= advancedMode ? csDir_r : {3'h0, csDir_r[0]};
		end
	end

	assign busy           = busy_r;
	assign accessDone     = done_r;
	assign accessArea     = area_r;
	assign accessExternal = ext_r;
	assign access8Bit     = is8_r;
	assign accessBurst    = burstAcc_r;
	assign accessStates   = states_r;
	assign accessWaits    = waits_r;
	assign busMode8Bit    = busMode8_r;
	assign partitionUnit  = unit_r;
	assign ramEnabled     = ramEn_r;
	assign chipSelOut_n   = csOut_r;
	assign chipSelOe      = csOe_r;
endmodule

/* hw/ebad_pkg.sv */
// package of constants for the external bus area decoder
// Behaviour
// - advanced mode: 16 MB split into eight areas
// - normal mode: 64 KB inside area 0 only
// - areas 0-3 drive active-low chip select
// - normal mode: only area 0 select produced
// - width bit 0 is 16-bit, 1 is 8-bit
// - 8-bit bus mode only when all areas 8-bit
// - state bit 0 two states, 1 three states
// - burst ROM area: one or two states
// - two-state space inserts no waits
// - three-state space: waits from two bits
// - on-chip accesses use fixed width and states
// - reset: basic interface, three-state, width by mode
// - advanced area 0 external except on-chip ROM
// - only area 0 may be burst ROM
// - areas 0-6 sized by partition unit
// - area 7 takes remaining top of range
// - RAM range external when RAM disabled
// - normal mode excludes RAM, I/O, enabled ROM
// - chip select drives only when direction set
// - one state is one clock period
// - on-chip memory: one state, 16-bit path
// - partition unit: 0 small, 1 large, resets 1
package ebad_pkg;
	localparam int          AREA_NUM       = 8;
	localparam int          CS_NUM         = 4;
	localparam int          ADDR_W         = 24;
	// on-chip map in advanced mode
	localparam logic [23:0] ADV_ROM_END    = 24'h01ffff;
	localparam logic [23:0] ADV_RAM_BASE   = 24'hffec00;
	localparam logic [23:0] ADV_RAM_END    = 24'hfffbff;
	localparam logic [23:0] ADV_IO_BASE    = 24'hfffc00;
	// on-chip map in normal mode
	localparam logic [15:0] NRM_ROM_END    = 16'h7fff;
	localparam logic [15:0] NRM_RAM_BASE   = 16'hec00;
	localparam logic [15:0] NRM_RAM_END    = 16'hfbff;
	localparam logic [15:0] NRM_IO_BASE    = 16'hfc00;
	// unit-size index fields
	localparam int          IDX_LARGE_LSB  = 21;
	localparam int          IDX_SMALL_LSB  = 17;
	localparam int          SMALL_TOP_LSB  = 20;
	// reset values
	localparam logic [7:0]  STATE_RST      = 8'hff;
	localparam logic [7:0]  WAIT_RST       = 8'hff;
	localparam logic        UNIT_RST       = 1'h1;
	localparam logic        RAM_EN_RST     = 1'h1;
	localparam logic        BURST_RST      = 1'h0;
	localparam logic        BURST_TWO_RST  = 1'h1;
	// state counts and top area index
	localparam logic [2:0]  MEM_STATES     = 3'h1;
	localparam logic [2:0]  IO_STATES      = 3'h2;
	localparam logic [2:0]  TWO_STATES     = 3'h2;
	localparam logic [2:0]  THREE_STATES   = 3'h3;
	localparam logic [2:0]  BURST1_STATES  = 3'h1;
	localparam logic [2:0]  BURST2_STATES  = 3'h2;
	localparam logic [2:0]  AREA_TOP       = 3'h7;
endpackage

/* tb/ebad_decoder_sva.sv */
// checker of the decoder port timing
`timescale 1ns/10ps
module ebad_decoder_sva (
	// clock, reset, mode
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        advancedMode,
	// inputs
	input wire logic        cfgLoad,
	input wire logic        cfgPartitionUnit,
	input wire logic        cfgRamEnable,
	input wire logic [3:0]  cfgCsDirection,
	input wire logic [23:0] reqAddr,
	// outputs
	input wire logic        busy,
	input wire logic        accessDone,
	input wire logic [2:0]  accessArea,
	input wire logic        accessExternal,
	input wire logic        access8Bit,
	input wire logic        accessBurst,
	input wire logic [2:0]  accessStates,
	input wire logic [2:0]  accessWaits,
	input wire logic        busMode8Bit,
	input wire logic        partitionUnit,
	input wire logic        ramEnabled,
	input wire logic [3:0]  chipSelOut_n,
	input wire logic [3:0]  chipSelOe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [2:0] busyCnt_r;
	// length of the cycle just ended
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			busyCnt_r <= 3'h0;
		else
			busyCnt_r <= busy ? busyCnt_r + 3'h1 : 3'h0;
	end
	AST_CS_ONEHOT: assert property (busy |-> chipSelOut_n == (
		accessExternal ? ~(4'h1 << accessArea) : 4'hf)) else $error("select mismatch");
	AST_CS_IDLE: assert property (!busy |-> chipSelOut_n == 4'hf) else $error("select while idle");
	AST_NRM_CS: assert property (!advancedMode |-> chipSelOut_n[3:1] == 3'h7 && chipSelOe[3:1] == 3'h0)
		else $error("upper select in normal mode");
	AST_TWO_NOWAIT: assert property (accessStates == 3'h2 |-> accessWaits == 3'h0) else $error("waits");
	AST_ONCHIP: assert property (busy && !accessExternal |-> !access8Bit && accessWaits == 3'h0
		&& (accessStates == 3'h1 || accessStates == 3'h2)) else $error("on-chip cycle");
	AST_DONE_LEN: assert property (accessDone |-> busyCnt_r == accessStates + accessWaits)
		else $error("cycle length");
	AST_DONE_PULSE: assert property ($fell(busy) |-> accessDone ##1 !accessDone) else $error("done pulse");
	AST_BUS8: assert property (busMode8Bit && busy && accessExternal |-> access8Bit && !accessBurst)
		else $error("bus mode");
	AST_CFG: assert property (cfgLoad |=> partitionUnit == $past(cfgPartitionUnit)
		&& ramEnabled == $past(cfgRamEnable)) else $error("config load");
	AST_OE: assert property (cfgLoad && advancedMode |-> ##2 chipSelOe == $past(cfgCsDirection, 2))
		else $error("pin enable");
	AST_BURST: assert property (busy && accessBurst |-> accessExternal && !access8Bit && accessWaits == 3'h0
		&& (advancedMode ? accessArea == 3'h0 : 1'b1) && (accessStates == 3'h1 || accessStates == 3'h2))
		else $error("burst cycle");
	AST_AREA: assert property ($rose(busy) && advancedMode && partitionUnit
		|-> accessArea == $past(reqAddr[23:21])) else $error("area index");
endmodule
bind ebad_decoder ebad_decoder_sva u_sva (.sys_clk, .nrst, .advancedMode, .cfgLoad, .cfgPartitionUnit,
	.cfgRamEnable, .cfgCsDirection, .reqAddr, .busy, .accessDone, .accessArea, .accessExternal, .access8Bit,
	.accessBurst, .accessStates, .accessWaits, .busMode8Bit, .partitionUnit, .ramEnabled, .chipSelOut_n,
	.chipSelOe);

/* tb/ebad_decoder_tb_top.sv */
// self-checking bench of the decoder
`timescale 1ns/10ps
module ebad_decoder_tb_top;
	logic sys_clk = 1'b0, nrst = 1'b0, advancedMode = 1'b1, romEnable = 1'b0, busWidth8Strap = 1'b0;
	logic cfgLoad = 1'b0, cfgPartitionUnit = 1'b1, cfgRamEnable = 1'b1, cfgBurstRom = 1'b0;
	logic cfgBurstTwoState = 1'b1, reqValid = 1'b0, memClr = 1'b0;
	logic [7:0] cfgAreaWidth = 8'h00, cfgAreaState = 8'hff, cfgWaitHigh = 8'hff, cfgWaitLow = 8'hff;
	logic [3:0] cfgCsDirection = 4'h1, csSeen, chipSelOut_n, chipSelOe;
	logic [23:0] reqAddr = 24'h0;
	logic busy, accessDone, accessExternal, access8Bit, accessBurst, busMode8Bit, partitionUnit, ramEnabled;
	logic [2:0] accessArea, accessStates, accessWaits;
	logic [31:0] rnd = 32'h26728bc5;
	logic [14:0] q[$];
	int fails = 0, cmp_count = 0;
	ebad_decoder dut (.sys_clk, .nrst, .advancedMode, .romEnable, .busWidth8Strap, .cfgLoad, .cfgAreaWidth,
		.cfgAreaState, .cfgWaitHigh, .cfgWaitLow, .cfgPartitionUnit, .cfgRamEnable, .cfgBurstRom,
		.cfgBurstTwoState, .cfgCsDirection, .reqValid, .reqAddr, .busy, .accessDone, .accessArea,
		.accessExternal, .access8Bit, .accessBurst, .accessStates, .accessWaits, .busMode8Bit,
		.partitionUnit, .ramEnabled, .chipSelOut_n, .chipSelOe);
	ebad_mem_model mem (.sys_clk, .nrst, .chipSelOut_n, .chipSelOe, .clr(memClr), .seen(csSeen));
	initial forever #2 sys_clk = ~sys_clk;
	////////////////////
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task step();
		rnd = lfsr(rnd);
	endtask
	task chk(input string nm, input logic [14:0] e, input logic [14:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task summarize();
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// {selects, area, external, 8-bit, states, waits}
	function logic [14:0] expf(input logic [23:0] a);
		logic [2:0] ar;
		logic [3:0] cs;
		ar = !advancedMode ? 3'h0 : cfgPartitionUnit ? a[23:21] : (a[23:20] != 4'h0) ? 3'h7 : a[19:17];
		cs = cfgCsDirection & (4'h1 << ar);
		if (advancedMode ? (romEnable && a <= ebad_pkg::ADV_ROM_END) || (cfgRamEnable && a inside
			{[ebad_pkg::ADV_RAM_BASE:ebad_pkg::ADV_RAM_END]}) : (romEnable && a[15:0] <= ebad_pkg::NRM_ROM_END)
			|| (cfgRamEnable && a[15:0] inside {[ebad_pkg::NRM_RAM_BASE:ebad_pkg::NRM_RAM_END]}))
			return {4'h0, ar, 2'b00, 3'h1, 3'h0};
		if (advancedMode ? a >= ebad_pkg::ADV_IO_BASE : a[15:0] >= ebad_pkg::NRM_IO_BASE)
			return {4'h0, ar, 2'b00, 3'h2, 3'h0};
		if (cfgBurstRom && ar == 3'h0)
			return {cs, ar, 1'b1, 1'b0, cfgBurstTwoState ? 3'h2 : 3'h1, 3'h0};
		return {cs, ar, 1'b1, cfgAreaWidth[ar], cfgAreaState[ar] ? 3'h3 : 3'h2,
			cfgAreaState[ar] ? {1'b0, cfgWaitHigh[ar], cfgWaitLow[ar]} : 3'h0};
	endfunction
	task rst(input logic adv, input logic rom, input logic w8);
		// the run starts in reset, so only a mid-run reset lets the last cycle drain first
		if (nrst)
			repeat (8) @(negedge sys_clk);
		nrst = 1'b0;
		{advancedMode, romEnable, busWidth8Strap} = {adv, rom, w8};
		{cfgAreaWidth, cfgAreaState, cfgWaitHigh, cfgWaitLow} = {{8{w8}}, 24'hffffff};
		{cfgPartitionUnit, cfgRamEnable, cfgBurstRom, cfgBurstTwoState} = 4'hd;
		cfgCsDirection = {3'h0, ~rom};
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("reset", {8'h0, 2'b11, w8, cfgCsDirection}, {8'h0, partitionUnit, ramEnabled, busMode8Bit, chipSelOe});
	endtask
	task cfg(input logic unit, input logic ram, input logic burst, input logic all8);
		while (busy !== 1'b0) @(negedge sys_clk);
		step();
		{cfgAreaState, cfgWaitHigh, cfgWaitLow} = rnd[31:8];
		cfgAreaWidth = all8 ? 8'hff : rnd[7:0];
		step();
		{cfgCsDirection, cfgBurstTwoState} = rnd[4:0];
		{cfgPartitionUnit, cfgRamEnable, cfgBurstRom} = {unit, ram, burst};
		cfgLoad = 1'b1;
		@(negedge sys_clk);
		cfgLoad = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("config", {8'h0, unit, ram, &cfgAreaWidth && !burst, advancedMode ? cfgCsDirection :
			{3'h0, cfgCsDirection[0]}}, {8'h0, partitionUnit, ramEnabled, busMode8Bit, chipSelOe});
	endtask
	// request held until taken; hold keeps it up for a back-to-back follower
	task acc(input logic [23:0] a, input logic hold);
		q.push_back(expf(a));
		reqAddr = a;
		reqValid = 1'b1;
		while (busy !== 1'b0) @(negedge sys_clk);
		@(negedge sys_clk);
		if (!hold)
			reqValid = 1'b0;
	endtask
	always @(negedge sys_clk) begin
		memClr <= (accessDone === 1'b1);
		if (accessDone === 1'b1)
			chk("access", q.size() > 0 ? q.pop_front() : 'x, {csSeen, accessArea, accessExternal,
				access8Bit, accessStates, accessWaits});
	end
	initial begin
		logic [23:0] a;
		rst(1'b1, 1'b0, 1'b0);
		acc(24'h200000, 1'b1);
		acc(24'h000100, 1'b0);
		for (int i = 0; i < 24; i++) begin
			cfg(i[0], i[1], i[2] & i[3], i >= 16);
			for (int k = 0; k < 6; k++) begin
				step();
				a = rnd[23:0];
				if (k == 1) a[23:20] = 4'h0;
				if (k == 2) a[23:12] = 12'hfff;
				if (k == 3) a[23:17] = 7'h0;
				acc(a, k != 5);
			end
		end
		rst(1'b0, 1'b1, 1'b1);
		acc(24'h008000, 1'b0);
		for (int i = 0; i < 8; i++) begin
			cfg(1'b0, i[0], i[1], 1'b0);
			for (int k = 0; k < 4; k++) begin
				step();
				a = {8'h0, (k == 1) ? 4'hf : rnd[15:12], rnd[11:0]};
				acc(a, k != 3);
			end
		end
		repeat (10) @(negedge sys_clk);
		summarize();
	end
	// about one thousand cycles are expected
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		summarize();
	end
endmodule

/* tb/ebad_mem_model.sv */
// external memory side: select pins as the memories see them
`timescale 1ns/10ps
module ebad_mem_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// select pins and clear
	input  wire logic [3:0] chipSelOut_n,
	input  wire logic [3:0] chipSelOe,
	input  wire logic       clr,
	// selects seen since last clear
	output logic [3:0]      seen
);
	logic [3:0] pinLvl;
	// an undriven pin floats to the board pull-up, so it never selects a memory
	assign pinLvl = chipSelOut_n | ~chipSelOe;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			seen <= 4'h0;
		else
			seen <= clr ? 4'h0 : seen | ~pinLvl;
	end
endmodule
